// [include/gpm_pkg.sv]
`default_nettype none
package gpm_pkg;
    // port widths and flat pad numbering: A, then B, then C, then D
    localparam int PORT_A_PINS = 12;
    localparam int PORT_B_PINS = 9;
    localparam int PORT_C_PINS = 8;
    localparam int PORT_D_PINS = 6;
    localparam int BASE_A      = 0;
    localparam int BASE_B      = BASE_A + PORT_A_PINS;
    localparam int BASE_C      = BASE_B + PORT_B_PINS;
    localparam int BASE_D      = BASE_C + PORT_C_PINS;
    localparam int NUM_PINS    = BASE_D + PORT_D_PINS;

    // peripheral function slots per pad, addressed by a 2-bit select field
    localparam int SEL_W      = 2;
    localparam int FUNC_SLOTS = 4;

    // pads named by flat index (port B packs B0..B3, B5..B7, B10, B11)
    localparam int PIN_A4  = BASE_A + 4;
    localparam int PIN_A6  = BASE_A + 6;
    localparam int PIN_A7  = BASE_A + 7;
    localparam int PIN_A8  = BASE_A + 8;
    localparam int PIN_B0  = BASE_B + 0;
    localparam int PIN_B2  = BASE_B + 2;
    localparam int PIN_B5  = BASE_B + 4;
    localparam int PIN_B6  = BASE_B + 5;
    localparam int PIN_B7  = BASE_B + 6;
    localparam int PIN_C0  = BASE_C + 0;
    localparam int PIN_D5  = BASE_D + 5;
    localparam int TEST_PORT_PINS = 4;

    // select codes of the external clock input on the clock-capable pads
    localparam logic [1:0] CLK_SEL_B5 = 2'h2;
    localparam logic [1:0] CLK_SEL_B6 = 2'h2;
    localparam logic [1:0] CLK_SEL_D5 = 2'h1;

    // reset values of the select state
    localparam logic [1:0] SEL_RESET     = 2'h0;
    localparam logic       CLK_PIN_RESET = 1'h0;

    // number of peripheral functions that each pad offers
    function automatic logic [1:0] func_count(input int pin);
        logic [1:0] n;
        n = 2'h1;
        if (pin == PIN_A4 || pin == BASE_A + 5 || pin == PIN_A8 || pin == BASE_A + 9 ||
            pin == PIN_B2 || pin == BASE_B + 3 || pin == PIN_B5 || pin == PIN_B6) begin
            n = 2'h3;
        end else if (pin == PIN_A6 || pin == PIN_B0 || pin == BASE_B + 1 ||
                     pin == PIN_B7 || pin == PIN_C0 || pin == BASE_C + 2 ||
                     pin == BASE_C + 3 || pin == BASE_C + 4 || pin == BASE_C + 6 ||
                     pin == BASE_C + 7 || pin == PIN_D5) begin
            n = 2'h2;
        end
        return n;
    endfunction

    // pads that leave reset owned by their dedicated function
    function automatic logic periph_at_reset(input int pin);
        return (pin == PIN_A7) || (pin >= BASE_D && pin < BASE_D + TEST_PORT_PINS);
    endfunction
endpackage
`default_nettype wire

// [include/gpm_sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface gpm_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport producer (output raw, input synced);
    modport syncer (input raw, output synced);
endinterface
`default_nettype wire

// [hdl/gpm_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module gpm_sync (
    // clock and reset
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    // raw pad levels in, resolved levels out
    gpm_sync_if.syncer    sync_bus
);
    logic [$bits(sync_bus.raw)-1:0] stage1_r;
    logic [$bits(sync_bus.raw)-1:0] stage1_nxt;
    logic [$bits(sync_bus.raw)-1:0] stage2_r;
    logic [$bits(sync_bus.raw)-1:0] stage2_nxt;

    // two-flop chain, first stage read only by the second
    always_comb begin
        stage1_nxt = sync_bus.raw;
        stage2_nxt = stage1_r;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= stage1_nxt;
            stage2_r <= stage2_nxt;
        end
    end

    assign sync_bus.synced = stage2_r;
endmodule // gpm_sync
`default_nettype wire

// [hdl/gpm_pin_mux.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - port A twelve pads, reset pad dedicated
// - port B nine pads, all port after reset
// - port C eight pads, all port after reset
// - port D six pads, four test-port after reset
// - A4 picks pulse out, timer, fault 1
// - A6 picks fault 0 or timer channel 0
// - A8 picks fault 1, timer, comparator input
// - B0 picks serial clock or I2C clock
// - B2 picks master-in, timer, pulse source
// - clock input needs clock block enable too
// - B6 picks receive, I2C data, clock input
// - B7 picks transmit or I2C clock
// - C0 picks analog input or comparator input
// - D5 uses its own clock-pin select
module gpm_pin_mux #(
    parameter int NUM_PINS   = gpm_pkg::NUM_PINS,
    parameter int FUNC_SLOTS = gpm_pkg::FUNC_SLOTS
) (
    // clock and reset
    input  wire logic                             clk_in,
    input  wire logic                             rst_in,
    // select state writes
    input  wire logic                             sel_wr_in,
    input  wire logic [NUM_PINS-1:0]              sel_enable_in,
    input  wire logic [NUM_PINS*2-1:0]            sel_field_in,
    input  wire logic                             clk_pin_sel_wr_in,
    input  wire logic                             clk_pin_sel_in,
    input  wire logic                             ext_clock_enable_in,
    // select state readback
    output logic      [NUM_PINS-1:0]              sel_enable_out,
    output logic      [NUM_PINS*2-1:0]            peripheral_select_reg_out,
    output logic                                  clock_pin_select_reg_out,
    // general-purpose port logic
    input  wire logic [NUM_PINS-1:0]              port_dout_in,
    input  wire logic [NUM_PINS-1:0]              port_dir_in,
    output logic      [NUM_PINS-1:0]              port_din_out,
    // peripheral functions, FUNC_SLOTS per pad
    input  wire logic [NUM_PINS*FUNC_SLOTS-1:0]   periph_dout_in,
    input  wire logic [NUM_PINS*FUNC_SLOTS-1:0]   periph_oe_in,
    output logic      [NUM_PINS*FUNC_SLOTS-1:0]   periph_din_out,
    output logic                                  external_clock_input_out,
    // package pads
    input  wire logic [NUM_PINS-1:0]              pad_in,
    output logic      [NUM_PINS-1:0]              pad_out,
    output logic      [NUM_PINS-1:0]              pad_oe_out
);
    localparam int SEL_W = gpm_pkg::SEL_W;

    // select state
    logic [NUM_PINS-1:0]       enable_r;
    logic [NUM_PINS-1:0]       enable_nxt;
    logic [NUM_PINS*SEL_W-1:0] select_r;
    logic [NUM_PINS*SEL_W-1:0] select_nxt;
    logic                      clk_pin_sel_r;
    logic                      clk_pin_sel_nxt;
    logic [NUM_PINS-1:0]       enable_reset;

    // pad-facing state
    logic [NUM_PINS-1:0]            pad_out_r;
    logic [NUM_PINS-1:0]            pad_out_nxt;
    logic [NUM_PINS-1:0]            pad_oe_r;
    logic [NUM_PINS-1:0]            pad_oe_nxt;
    logic [NUM_PINS-1:0]            port_din_r;
    logic [NUM_PINS-1:0]            port_din_nxt;
    logic [NUM_PINS*FUNC_SLOTS-1:0] periph_din_r;
    logic [NUM_PINS*FUNC_SLOTS-1:0] periph_din_nxt;
    logic [NUM_PINS-1:0]            clk_pick;
    logic                           ext_clk_r;
    logic                           ext_clk_nxt;
    logic [NUM_PINS-1:0]            pad_sync;

    // pad inputs cross into the clock domain through two flops
    gpm_sync_if #(.WIDTH(NUM_PINS)) sync_bus ();

    assign sync_bus.raw = pad_in;
    assign pad_sync     = sync_bus.synced;

    gpm_sync u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .sync_bus (sync_bus.syncer)
    );

    // reset ownership: reset pad and test-port pads dedicated, rest port
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_rst
            assign enable_reset[g] = gpm_pkg::periph_at_reset(g);
        end
    endgenerate

    // select state next values, loaded whole on a write strobe
    // a field write and a clock-pin write may land in the same cycle
    always_comb begin
        enable_nxt      = enable_r;
        select_nxt      = select_r;
        clk_pin_sel_nxt = clk_pin_sel_r;
        if (sel_wr_in) begin
            enable_nxt = sel_enable_in;
            select_nxt = sel_field_in;
        end
        if (clk_pin_sel_wr_in) begin
            clk_pin_sel_nxt = clk_pin_sel_in;
        end
    end

    // select state registers; select fields start at the first function
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_r      <= enable_reset;
            select_r      <= {NUM_PINS{gpm_pkg::SEL_RESET}};
            clk_pin_sel_r <= gpm_pkg::CLK_PIN_RESET;
        end else begin
            enable_r      <= enable_nxt;
            select_r      <= select_nxt;
            clk_pin_sel_r <= clk_pin_sel_nxt;
        end
    end

    // per-pad ownership and routing
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic [SEL_W-1:0]      sel;
            logic                  sel_ok;
            logic                  is_clk;
            logic                  periph_mode;
            logic                  route_in;
            logic                  pin_out;
            logic                  pin_oe;
            logic                  pin_port_din;
            logic [FUNC_SLOTS-1:0] pin_slot_din;

            // D5 takes its choice from the clock-pin select alone
            always_comb begin
                if (g == gpm_pkg::PIN_D5) begin
                    sel = {1'h0, clk_pin_sel_r};
                end else begin
                    sel = select_r[g*SEL_W +: SEL_W];
                end
            end

            // a code past the pad's function count leaves the pad to the port
            assign sel_ok      = sel < gpm_pkg::func_count(g);
            assign periph_mode = enable_r[g] && sel_ok;

            // clock-input choices on B5, B6 and D5
            assign is_clk = (g == gpm_pkg::PIN_B5 && sel == gpm_pkg::CLK_SEL_B5) ||
                            (g == gpm_pkg::PIN_B6 && sel == gpm_pkg::CLK_SEL_B6) ||
                            (g == gpm_pkg::PIN_D5 && sel == gpm_pkg::CLK_SEL_D5);

            // clock input reaches logic only with the clock block's enable
            // an unenabled clock choice still owns the pad but feeds nothing
            assign route_in    = periph_mode && !(is_clk && !ext_clock_enable_in);
            assign clk_pick[g] = periph_mode && is_clk && ext_clock_enable_in;

            // pad drive: chosen peripheral or port data and direction
            always_comb begin
                if (periph_mode) begin
                    pin_out = periph_dout_in[g*FUNC_SLOTS + int'(sel)];
                    pin_oe  = periph_oe_in[g*FUNC_SLOTS + int'(sel)] && !is_clk;
                end else begin
                    pin_out = port_dout_in[g];
                    pin_oe  = port_dir_in[g];
                end
            end

            // pad sampling: port sees the pad only while it owns it
            // a peripheral-owned pad reads back as 0 on the port side
            always_comb begin
                pin_port_din = periph_mode ? 1'h0 : pad_sync[g];
                for (int f = 0; f < FUNC_SLOTS; f++) begin
                    pin_slot_din[f] = route_in && (int'(sel) == f) && pad_sync[g];
                end
            end

            // each pad drives only its own slice of the shared next values
            assign pad_out_nxt[g]                             = pin_out;
            assign pad_oe_nxt[g]                              = pin_oe;
            assign port_din_nxt[g]                            = pin_port_din;
            assign periph_din_nxt[g*FUNC_SLOTS +: FUNC_SLOTS] = pin_slot_din;
        end
    endgenerate

    // external clock level from whichever enabled pad carries it
    // only one clock choice should be live; several are simply ORed
    always_comb begin
        ext_clk_nxt = |(clk_pick & pad_sync);
    end

    // output stage registers
    // one register stage keeps every pad, port-input, peripheral-input and external clock output glitch-free
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pad_out_r    <= '0;
            pad_oe_r     <= '0;
            port_din_r   <= '0;
            periph_din_r <= '0;
            ext_clk_r    <= 1'h0;
        end else begin
            pad_out_r    <= pad_out_nxt;
            pad_oe_r     <= pad_oe_nxt;
            port_din_r   <= port_din_nxt;
            periph_din_r <= periph_din_nxt;
            ext_clk_r    <= ext_clk_nxt;
        end
    end

    // all outputs straight from flops
    assign pad_out                    = pad_out_r;
    assign pad_oe_out                 = pad_oe_r;
    assign port_din_out               = port_din_r;
    assign periph_din_out             = periph_din_r;
    assign external_clock_input_out   = ext_clk_r;
    assign sel_enable_out             = enable_r;
    assign peripheral_select_reg_out  = select_r;
    assign clock_pin_select_reg_out   = clk_pin_sel_r;
endmodule // gpm_pin_mux
`default_nettype wire

// [tb/gpm_mux_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module gpm_mux_checker #(
    parameter int NUM_PINS   = 35,
    parameter int FUNC_SLOTS = 4
) (
    // clock and reset
    input wire logic                           clk_in,
    input wire logic                           rst_in,
    // select writes and state
    input wire logic                           sel_wr_in,
    input wire logic [NUM_PINS-1:0]            sel_enable_in,
    input wire logic [NUM_PINS*2-1:0]          sel_field_in,
    input wire logic                           clk_pin_sel_wr_in,
    input wire logic                           clk_pin_sel_in,
    input wire logic [NUM_PINS-1:0]            sel_enable_out,
    input wire logic [NUM_PINS*2-1:0]          peripheral_select_reg_out,
    input wire logic                           clock_pin_select_reg_out,
    // port, peripheral and pad side
    input wire logic [NUM_PINS-1:0]            port_dout_in,
    input wire logic [NUM_PINS-1:0]            port_dir_in,
    input wire logic [NUM_PINS-1:0]            port_din_out,
    input wire logic [NUM_PINS*FUNC_SLOTS-1:0] periph_dout_in,
    input wire logic [NUM_PINS-1:0]            pad_in,
    input wire logic [NUM_PINS-1:0]            pad_out,
    input wire logic [NUM_PINS-1:0]            pad_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // pad 0 left to the port for four cycles running
    sequence s_port_held;
        !rst_in && !sel_enable_out[0] ##1 !sel_enable_out[0] [*3];
    endsequence
    // ownership and selects after reset release
    reset_values_a: assert property ($fell(rst_in) |-> sel_enable_out == 35'h1E0000080 &&
        peripheral_select_reg_out == '0 && !clock_pin_select_reg_out) else $error("reset state");
    sel_write_a: assert property (sel_wr_in |=> sel_enable_out == $past(sel_enable_in) &&
        peripheral_select_reg_out == $past(sel_field_in)) else $error("select load");
    clk_pin_write_a: assert property (clk_pin_sel_wr_in |=>
        clock_pin_select_reg_out == $past(clk_pin_sel_in)) else $error("clock pin load");
    port_drive_a: assert property (!rst_in && !sel_enable_out[0] |=>
        pad_out[0] == $past(port_dout_in[0]) && pad_oe_out[0] == $past(port_dir_in[0]))
        else $error("port drive");
    periph_drive_a: assert property (!rst_in && sel_enable_out[4] &&
        peripheral_select_reg_out[9:8] == 2'h1 |=> pad_out[4] == $past(periph_dout_in[17]))
        else $error("peripheral drive");
    range_refused_a: assert property (!rst_in && sel_enable_out[6] &&
        peripheral_select_reg_out[13:12] >= 2'h2 |=> pad_oe_out[6] == $past(port_dir_in[6]))
        else $error("out of range code");
    clock_no_drive_a: assert property (!rst_in && sel_enable_out[17] &&
        peripheral_select_reg_out[35:34] == 2'h2 |=> !pad_oe_out[17]) else $error("clock pad driven");
    port_sample_a: assert property (s_port_held |-> port_din_out[0] == $past(pad_in[0], 3))
        else $error("port sample");
endmodule // gpm_mux_checker
bind gpm_pin_mux gpm_mux_checker #(.NUM_PINS(NUM_PINS), .FUNC_SLOTS(FUNC_SLOTS)) chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .sel_wr_in(sel_wr_in), .sel_enable_in(sel_enable_in),
    .sel_field_in(sel_field_in), .clk_pin_sel_wr_in(clk_pin_sel_wr_in),
    .clk_pin_sel_in(clk_pin_sel_in), .sel_enable_out(sel_enable_out),
    .peripheral_select_reg_out(peripheral_select_reg_out),
    .clock_pin_select_reg_out(clock_pin_select_reg_out), .port_dout_in(port_dout_in),
    .port_dir_in(port_dir_in), .port_din_out(port_din_out), .periph_dout_in(periph_dout_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out));
`default_nettype wire

// [tb/gpm_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module gpm_far_model #(
    parameter int NUM_PINS = 35
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // port logic and peripheral drive
    output logic [NUM_PINS-1:0]       port_dout_out,
    output logic [NUM_PINS-1:0]       port_dir_out,
    output logic [NUM_PINS*4-1:0]     periph_dout_out,
    output logic [NUM_PINS*4-1:0]     periph_oe_out
);
    logic phase_r;
    logic phase_nxt;
    // flip every cycle so a stale sample shows up
    always_comb begin
        phase_nxt = ~phase_r;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_r <= 1'h0;
        end else begin
            phase_r <= phase_nxt;
        end
    end
    // slots 0..2 give distinct data and enable pairs
    assign port_dout_out   = {NUM_PINS{phase_r}};
    assign port_dir_out    = {NUM_PINS{~phase_r}};
    assign periph_dout_out = {NUM_PINS{4'h6}} ^ {(NUM_PINS*4){phase_r}};
    assign periph_oe_out   = {NUM_PINS{4'hC}} ^ {(NUM_PINS*4){phase_r}};
endmodule // gpm_far_model
`default_nettype wire

// [tb/tb_gpio_port_pin_mux.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_port_pin_mux;
    localparam int NP = gpm_pkg::NUM_PINS;
    logic            clk_in, rst_in, sel_wr_in, clk_pin_sel_wr_in, clk_pin_sel_in, ext_clk_en;
    logic [NP-1:0]   sel_enable_in, pad_in;
    logic [NP*2-1:0] sel_field_in;
    wire logic [NP-1:0]   sel_en_q, p_dout, p_dir, port_din_out, pad_out, pad_oe_out;
    wire logic [NP*2-1:0] sel_q;
    wire logic [NP*4-1:0] f_dout, f_oe, periph_din_out;
    wire logic            clk_sel_q, ext_clk_q;
    int              n_mismatch = 0;
    int              n_compared = 0;
    gpm_pin_mux dut_u (.clk_in(clk_in), .rst_in(rst_in), .sel_wr_in(sel_wr_in),
        .sel_enable_in(sel_enable_in), .sel_field_in(sel_field_in),
        .clk_pin_sel_wr_in(clk_pin_sel_wr_in), .clk_pin_sel_in(clk_pin_sel_in),
        .ext_clock_enable_in(ext_clk_en), .sel_enable_out(sel_en_q),
        .peripheral_select_reg_out(sel_q), .clock_pin_select_reg_out(clk_sel_q),
        .port_dout_in(p_dout), .port_dir_in(p_dir), .port_din_out(port_din_out),
        .periph_dout_in(f_dout), .periph_oe_in(f_oe), .periph_din_out(periph_din_out),
        .external_clock_input_out(ext_clk_q), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_out(pad_oe_out));
    gpm_far_model #(.NUM_PINS(NP)) far_u (.clk_in(clk_in), .rst_in(rst_in),
        .port_dout_out(p_dout), .port_dir_out(p_dir), .periph_dout_out(f_dout),
        .periph_oe_out(f_oe));
    // clock
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end
    // value compare
    task automatic cmp(input logic [139:0] got, input logic [139:0] exp_v, input string what);
        n_compared++;
        if (got !== exp_v) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr_sel(input logic [NP-1:0] en, input logic [NP*2-1:0] fld);
        @(posedge clk_in);
        sel_wr_in     <= 1'h1;
        sel_enable_in <= en;
        sel_field_in  <= fld;
        @(posedge clk_in);
        sel_wr_in <= 1'h0;
        #1;
    endtask
    // reset for three cycles, then check the default state
    task automatic t_reset();
        @(posedge clk_in);
        rst_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'h0;
        #1;
        cmp(140'({pad_oe_out, sel_en_q}), 140'({35'h0, 35'h1E0000080}),
            "reset owners");
        cmp(140'({sel_q, clk_sel_q}), 140'(71'h0), "reset selects");
    endtask
    // every slot of eight shared pads (A4, A6, A8, B0, B2, B7, C0, B6), plus the first code past the end
    task automatic t_sel_table();
        int pads[8] = '{4, 6, 8, 12, 14, 18, 21, 17};
        int cnt[8] = '{3, 2, 3, 2, 3, 2, 2, 3};
        logic [NP*2-1:0] fld;
        logic [NP*4-1:0] d, o;
        logic [NP-1:0] pd, pr;
        logic [1:0] want;
        for (int k = 0; k < 8; k++) begin
            for (int c = 0; c <= cnt[k]; c++) begin
                fld = '0;
                fld[2*pads[k] +: 2] = 2'(c);
                wr_sel(NP'(1) << pads[k], fld);
                cmp(140'({sel_en_q, sel_q}), 140'({NP'(1) << pads[k], fld}), "select");
                d = f_dout;
                o = f_oe;
                pd = p_dout;
                pr = p_dir;
                @(posedge clk_in);
                #1;
                want = (c == cnt[k]) ? {pd[pads[k]], pr[pads[k]]} : {d[4*pads[k]+c], o[4*pads[k]+c]};
                if (pads[k] == 17 && c == 2) begin
                    want[0] = 1'h0; // clock choice never drives the pad
                end
                cmp(140'({pad_out[pads[k]], pad_oe_out[pads[k]]}), 140'(want),
                    "pad drive");
            end
        end
    endtask
    // external clock on B6 gated by the enable, then on D5 by its own select
    task automatic t_clock();
        logic [NP*2-1:0] fld;
        fld = '0;
        fld[35:34] = 2'h2;
        wr_sel(NP'(1) << 17, fld);
        @(posedge clk_in);
        ext_clk_en <= 1'h1;
        pad_in[17] <= 1'h1;
        repeat (4) @(posedge clk_in);
        #1;
        cmp(140'({ext_clk_q, periph_din_out[70], pad_oe_out[17]}), 140'(3'h6), "b6 clock");
        @(posedge clk_in);
        ext_clk_en <= 1'h0;
        repeat (4) @(posedge clk_in);
        #1;
        cmp(140'({ext_clk_q, periph_din_out[70]}), 140'(2'h0), "clock gated");
        fld = '0;
        fld[69:68] = 2'h1;
        wr_sel(NP'(1) << 34, fld);
        @(posedge clk_in);
        clk_pin_sel_wr_in <= 1'h1;
        clk_pin_sel_in <= 1'h1;
        ext_clk_en <= 1'h1;
        pad_in <= NP'(1) << 34;
        @(posedge clk_in);
        clk_pin_sel_wr_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        #1;
        cmp(140'({clk_sel_q, ext_clk_q, pad_oe_out[34]}), 140'(3'h6), "d5 clock");
    endtask
    // port-owned pad level reaches the port, not the peripherals
    task automatic t_sample();
        wr_sel('0, '0);
        @(posedge clk_in);
        pad_in <= NP'(1);
        repeat (4) @(posedge clk_in);
        #1;
        cmp(140'({port_din_out[0], periph_din_out[3:0]}), 140'(5'h10), "port sample");
    endtask
    // main sequence
    initial begin
        rst_in = 1'h1;
        sel_wr_in = 1'h0;
        clk_pin_sel_wr_in = 1'h0;
        clk_pin_sel_in = 1'h0;
        ext_clk_en = 1'h0;
        sel_enable_in = '0;
        sel_field_in = '0;
        pad_in = '0;
        t_reset();
        t_sel_table();
        t_clock();
        t_sample();
        t_reset();
        wrap_up();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk_in);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_gpio_port_pin_mux
`default_nettype wire
